// ==== rds_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

module rds_seq #(
  parameter int FAST_CONV_CYC = rds_pkg::FAST_CONV_CYC
) (
  input wire logic core_clk,                                   // Block clock, 200 MHz.
  input wire logic sys_rst,                                    // Asynchronous reset, active high.
  input wire logic soc_pulse,                                  // On-demand start, one cycle.
  input wire rds_pkg::rds_req_t soc_req,                       // Step requests of the start frame.
  input wire logic cycle_pulse,                                // Cyclic start, one cycle.
  input wire logic prior_done,                                 // Earlier routine steps finished.
  input wire rds_pkg::rds_ncyc_t ncycle,                       // Per-step cycle-count fields.
  input wire logic [2*rds_pkg::PIN_N-1:0] pin_config,          // Two-bit configuration per pin.
  input wire logic [rds_pkg::CELL_N-1:0] cell_channel_enable,  // Cell enables.
  input wire logic converter_cross_verify,                     // Cell check method select.
  input wire logic [rds_pkg::FILT_W-1:0] filter_soc,           // Filter for on-demand runs.
  input wire logic [rds_pkg::FILT_W-1:0] filter_cycle,         // Filter for cyclic runs.
  input wire rds_pkg::rds_sense_t sense,                       // Analog results, asynchronous.
  input wire logic fault_clear,                                // Host clears faults, one cycle.
  input wire logic done_read,                                  // Host reads the done flag.
  output logic busy,                                           // Sequence in progress.
  output logic diag_done,                                      // Diagnostic steps over, one cycle.
  output logic [rds_pkg::PIN_N-1:0] pin_pulldown_en,           // Pull-down current per pin.
  output logic [rds_pkg::TERM_N-1:0] cell_open_test_en,        // Cell terminal test per terminal.
  output logic cell_cross_mode,                                // Method used by the cell test.
  output logic [rds_pkg::CELL_N-1:0] balance_test_en,          // Balance segment test.
  output logic self_check_run,                                 // Built-in self-test active.
  output rds_pkg::rds_fault_t faults,                          // Sticky failure flags.
  output logic config_override,                                // Configuration override request.
  output logic self_check_finished                             // Self-check done flag.
);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (FAST_CONV_CYC < 1 || (FAST_CONV_CYC << 7) > 2 ** (rds_pkg::TMR_W - 2)) begin : g_chk
    $error("FAST_CONV_CYC out of range");
  end

  if (rds_pkg::TERM_N != rds_pkg::CELL_N + 1) begin : g_chk_term
    $error("TERM_N must be CELL_N plus one");
  end

  if (rds_pkg::NCYC_W != 3 || rds_pkg::FILT_W != 3) begin : g_chk_ncyc
    $error("Cycle-count and filter fields must be three bits wide");
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  rds_pkg::rds_state_t state_q;
  rds_pkg::rds_state_t state_d;
  rds_pkg::rds_req_t sel_q;
  rds_pkg::rds_req_t cyc_sel;
  rds_pkg::rds_sense_t sense_meta_q;
  rds_pkg::rds_sense_t sense_sync_q;
  rds_pkg::rds_fault_t faults_q;
  rds_pkg::rds_fault_t new_fault;
  logic cyclic_q;
  logic [rds_pkg::PERIOD_W-1:0] period_q;
  logic [rds_pkg::TMR_W-1:0] timer_q;
  logic [rds_pkg::TMR_W-1:0] dur_d;
  logic [rds_pkg::TMR_W-1:0] conv_cyc;
  logic [rds_pkg::FILT_W-1:0] filt;
  logic [rds_pkg::PIN_N-1:0] pin_mask;
  logic [rds_pkg::TERM_N-1:0] term_mask;
  logic step_end;
  logic busy_q;
  logic diag_done_q;
  logic [rds_pkg::PIN_N-1:0] pin_pulldown_q;
  logic [rds_pkg::TERM_N-1:0] cell_test_q;
  logic cross_mode_q;
  logic [rds_pkg::CELL_N-1:0] bal_test_q;
  logic self_run_q;
  logic override_q;
  logic finished_q;

  // ------------------------------------------------------------------
  // Step selection helpers
  // ------------------------------------------------------------------
  // Returns the first selected step at or after position from.
  function automatic rds_pkg::rds_state_t pick(input rds_pkg::rds_req_t s, input int from);
    rds_pkg::rds_state_t r;
    r = rds_pkg::RDS_IDLE;
    if (from <= 3 && s.self_check) begin
      r = rds_pkg::RDS_SELF;
    end
    if (from <= 2 && s.balance_path) begin
      r = rds_pkg::RDS_BAL;
    end
    if (from <= 1 && s.cell_open) begin
      r = rds_pkg::RDS_CELL;
    end
    if (from <= 0 && s.pin_open) begin
      r = rds_pkg::RDS_PIN;
    end
    return r;
  endfunction : pick

  // A step joins this cycle when its count is nonzero and the period count is aligned.
  function automatic logic due(input logic [rds_pkg::NCYC_W-1:0] n,
                               input logic [rds_pkg::PERIOD_W-1:0] p);
    return (n != rds_pkg::NCYC_EXCLUDED) && ((p & rds_pkg::OCCUR_MASK[n]) == '0);  // see R18
  endfunction : due

  always_comb begin
    cyc_sel.pin_open = due(ncycle.pin_open, period_q);                    // see R3
    cyc_sel.cell_open = due(ncycle.cell_open, period_q);                  // see R3
    cyc_sel.balance_path = due(ncycle.balance_path, period_q);            // see R3
    cyc_sel.self_check = due(ncycle.self_check, period_q);                // see R3
  end

  // ------------------------------------------------------------------
  // Skip masks
  // ------------------------------------------------------------------
  // Pins one and two are never tested; the rest only as analog inputs.
  always_comb begin
    pin_mask = '0;                                                        // see R4
    for (int i = 2; i < rds_pkg::PIN_N; i++) begin
      pin_mask[i] = (pin_config[2*i +: 2] == rds_pkg::PIN_CFG_ANALOG);    // see R4
    end
  end

  assign term_mask = {cell_channel_enable, cell_channel_enable[0]};       // see R8

  // ------------------------------------------------------------------
  // Step durations
  // ------------------------------------------------------------------
  assign filt = cyclic_q ? filter_cycle : filter_soc;                     // see R9
  assign conv_cyc = rds_pkg::TMR_W'(FAST_CONV_CYC) << filt;

  // The length is loaded on entry; the cell step follows the active filter.
  always_comb begin
    dur_d = '0;
    unique case (state_d)
      rds_pkg::RDS_PIN: begin
        dur_d = rds_pkg::TMR_W'(rds_pkg::PIN_OPEN_SETTLE_CYC + FAST_CONV_CYC);  // see R5
      end
      rds_pkg::RDS_CELL: begin
        dur_d = (rds_pkg::TMR_W'(rds_pkg::CELL_OPEN_SETTLE_CYC) + conv_cyc) << 1;  // see R9
      end
      rds_pkg::RDS_BAL: begin
        dur_d = rds_pkg::TMR_W'(2 * rds_pkg::BAL_OPENLOAD_CYC);           // see R12
      end
      rds_pkg::RDS_SELF: begin
        dur_d = rds_pkg::TMR_W'(3 * FAST_CONV_CYC);                       // see R15
      end
      rds_pkg::RDS_IDLE, rds_pkg::RDS_WAIT: begin
        dur_d = '0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  assign step_end = (timer_q == '0);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rds_pkg::RDS_IDLE: begin
        if (soc_pulse || cycle_pulse) begin
          state_d = rds_pkg::RDS_WAIT;
        end
      end
      rds_pkg::RDS_WAIT: begin
        if (prior_done) begin
          state_d = pick(sel_q, 0);                                       // see R1
        end
      end
      rds_pkg::RDS_PIN: begin
        if (step_end) begin
          state_d = pick(sel_q, 1);                                       // see R19
        end
      end
      rds_pkg::RDS_CELL: begin
        if (step_end) begin
          state_d = pick(sel_q, 2);                                       // see R19
        end
      end
      rds_pkg::RDS_BAL: begin
        if (step_end) begin
          state_d = pick(sel_q, 3);                                       // see R19
        end
      end
      rds_pkg::RDS_SELF: begin
        if (step_end) begin
          state_d = rds_pkg::RDS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= rds_pkg::RDS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Step timer reloads on every change of step, so a skipped step costs nothing.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_q <= '0;
    end else if (state_d != state_q) begin
      timer_q <= dur_d - rds_pkg::TMR_W'(1);                              // see R19
    end else if (timer_q != '0) begin
      timer_q <= timer_q - rds_pkg::TMR_W'(1);
    end
  end

  // Selection is taken only from the start frame itself or from the cycle counts.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_q <= '0;
      cyclic_q <= 1'b0;
    end else if (state_q == rds_pkg::RDS_IDLE && soc_pulse) begin
      sel_q <= soc_req;                                                   // see R2
      cyclic_q <= 1'b0;
    end else if (state_q == rds_pkg::RDS_IDLE && cycle_pulse) begin
      sel_q <= cyc_sel;                                                   // see R3
      cyclic_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_q <= '0;
    end else if (state_q == rds_pkg::RDS_IDLE && !soc_pulse && cycle_pulse) begin
      period_q <= period_q + rds_pkg::PERIOD_W'(1);                       // see R3
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      diag_done_q <= 1'b0;
    end else begin
      busy_q <= (state_d != rds_pkg::RDS_IDLE);
      diag_done_q <= (state_q != rds_pkg::RDS_IDLE) && (state_q != rds_pkg::RDS_WAIT)
                     && (state_d == rds_pkg::RDS_IDLE);
    end
  end

  // ------------------------------------------------------------------
  // Analog controls
  // ------------------------------------------------------------------
  // Step enables follow the next state, so each stands for exactly its step; cross mode copies converter_cross_verify every cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_pulldown_q <= '0;
      cell_test_q <= '0;
      cross_mode_q <= 1'b0;
      bal_test_q <= '0;
      self_run_q <= 1'b0;
    end else begin
      pin_pulldown_q <= (state_d == rds_pkg::RDS_PIN) ? pin_mask : '0;    // see R6
      cell_test_q <= (state_d == rds_pkg::RDS_CELL) ? term_mask : '0;     // see R8
      cross_mode_q <= converter_cross_verify;                             // see R7
      bal_test_q <= (state_d == rds_pkg::RDS_BAL) ? cell_channel_enable : '0;  // see R11
      self_run_q <= (state_d == rds_pkg::RDS_SELF);                       // see R14
    end
  end

  // ------------------------------------------------------------------
  // Result synchroniser
  // ------------------------------------------------------------------
  // Analog results change at any time; two flops guard against metastability.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sense_meta_q <= '0;
      sense_sync_q <= '0;
    end else begin
      sense_meta_q <= sense;
      sense_sync_q <= sense_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // Fault capture
  // ------------------------------------------------------------------
  // Results are judged in the last cycle of each step, only on tested channels.
  always_comb begin
    new_fault = '0;
    if (step_end && state_q == rds_pkg::RDS_PIN) begin
      new_fault.pin_open = sense_sync_q.pin_low & pin_pulldown_q;         // see R6
    end
    if (step_end && state_q == rds_pkg::RDS_CELL) begin
      new_fault.cell_open = sense_sync_q.cell_drop_high & cell_test_q;    // see R10
    end
    if (step_end && state_q == rds_pkg::RDS_BAL) begin
      new_fault.balance_open = sense_sync_q.balance_vds_low & bal_test_q;  // see R13
    end
    if (step_end && state_q == rds_pkg::RDS_SELF) begin
      new_fault.bist = sense_sync_q.bist;                                 // see R16
    end
  end

  // A fault arriving with the clear stays set.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      faults_q <= '0;
    end else begin
      faults_q <= (fault_clear ? '0 : faults_q) | new_fault;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      override_q <= 1'b0;
    end else begin
      override_q <= (override_q && !fault_clear) || (|new_fault);         // see R6 R10 R13 R16
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      finished_q <= 1'b0;
    end else begin
      finished_q <= (finished_q && !done_read)
                    || (step_end && state_q == rds_pkg::RDS_SELF);        // see R17
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign busy = busy_q;
  assign diag_done = diag_done_q;
  assign pin_pulldown_en = pin_pulldown_q;
  assign cell_open_test_en = cell_test_q;
  assign cell_cross_mode = cross_mode_q;
  assign balance_test_en = bal_test_q;
  assign self_check_run = self_run_q;
  assign faults = faults_q;
  assign config_override = override_q;
  assign self_check_finished = finished_q;

endmodule : rds_seq

`default_nettype wire

// ==== rds_pkg.sv ====
// Notes on behaviour
// R1 - Pin open check is optional step four.
// R2 - Host sends step requests with start command.
// R3 - Cyclic steps follow their own cycle counts.
// R4 - Pin check skips pins one, two, non-analog.
// R5 - Pin step lasts settle plus fastest conversion.
// R6 - Pull-down applied; low pin flags open fault.
// R7 - Cell open step five; cross-verify selects method.
// R8 - Terminal n needs cell n; terminal 0 cell 1.
// R9 - Cell step lasts twice settle plus conversion.
// R10 - Excess drop on cell path flags open fault.
// R11 - Balance step six, segments of disabled cells skipped.
// R12 - Balance step lasts twice open-load interval.
// R13 - Low switch drop flags balance open fault.
// R14 - Self-check step seven tests everything, never skips.
// R15 - Self-check lasts three fastest conversion cycles.
// R16 - Self-check raises separate path and comparator faults.
// R17 - Self-check done flag, cleared by host read.
// R18 - Count zero excludes step; one runs every cycle.
// R19 - Steps run in order; unselected take no time.

package rds_pkg;

  // ------------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------------
  localparam int PIN_N = 9;
  localparam int TERM_N = 15;
  localparam int CELL_N = 14;
  localparam int FILT_W = 3;
  localparam int NCYC_W = 3;
  localparam int PERIOD_W = 11;
  localparam int TMR_W = 24;
  localparam int CLK_PERIOD_NS = 5;
  localparam int FAST_CONV_NS = 10000;
  localparam int PIN_OPEN_SETTLE_NS = 5000;
  localparam int CELL_OPEN_SETTLE_NS = 4000;
  localparam int BAL_OPENLOAD_NS = 15000;
  localparam int FAST_CONV_CYC = (FAST_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_OPEN_SETTLE_CYC = (PIN_OPEN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CELL_OPEN_SETTLE_CYC = (CELL_OPEN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BAL_OPENLOAD_CYC = (BAL_OPENLOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PIN_CFG_ANALOG = 2'h0;
  localparam logic [NCYC_W-1:0] NCYC_EXCLUDED = 3'h0;
  localparam logic [PERIOD_W-1:0] OCCUR_MASK [8] = '{11'h000, 11'h000, 11'h003, 11'h00f,
                                                    11'h03f, 11'h07f, 11'h1ff, 11'h3ff};

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RDS_IDLE, RDS_WAIT, RDS_PIN, RDS_CELL, RDS_BAL, RDS_SELF
  } rds_state_t;

  typedef struct packed {
    logic self_check;
    logic balance_path;
    logic cell_open;
    logic pin_open;
  } rds_req_t;

  typedef struct packed {
    logic [NCYC_W-1:0] self_check;
    logic [NCYC_W-1:0] balance_path;
    logic [NCYC_W-1:0] cell_open;
    logic [NCYC_W-1:0] pin_open;
  } rds_ncyc_t;

  typedef struct packed {
    logic cell_path;
    logic sense_path;
    logic pin_path;
    logic stack_comparator;
    logic regulator_comparator;
    logic comm_supply_comparator;
    logic reference_comparator;
    logic balance_high_side;
    logic balance_low_side;
  } rds_bist_t;

  typedef struct packed {
    logic [PIN_N-1:0] pin_low;
    logic [TERM_N-1:0] cell_drop_high;
    logic [CELL_N-1:0] balance_vds_low;
    rds_bist_t bist;
  } rds_sense_t;

  typedef struct packed {
    logic [PIN_N-1:0] pin_open;
    logic [TERM_N-1:0] cell_open;
    logic [CELL_N-1:0] balance_open;
    rds_bist_t bist;
  } rds_fault_t;

endpackage : rds_pkg

// ==== rds_seq_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module rds_seq_chk #(
  parameter int FAST_CONV_CYC = rds_pkg::FAST_CONV_CYC
) (
  input wire logic core_clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic soc_pulse, // Start.
  input wire logic cycle_pulse, // Cyclic start.
  input wire logic [2*rds_pkg::PIN_N-1:0] pin_config, // Pin modes.
  input wire logic [rds_pkg::CELL_N-1:0] cell_channel_enable, // Cell enables.
  input wire logic fault_clear, // Clear.
  input wire logic done_read, // Flag read.
  input wire logic busy, // Busy.
  input wire logic diag_done, // End pulse.
  input wire logic [rds_pkg::PIN_N-1:0] pin_pulldown_en, // Pin test.
  input wire logic [rds_pkg::TERM_N-1:0] cell_open_test_en, // Terminal test.
  input wire logic [rds_pkg::CELL_N-1:0] balance_test_en, // Balance test.
  input wire logic self_check_run, // Self-check.
  input wire rds_pkg::rds_fault_t faults, // Faults.
  input wire logic config_override, // Override.
  input wire logic self_check_finished // Done flag.
);
  // ----
  // Run-length counters
  // ----
  logic [15:0] pin_run_q;
  logic [15:0] self_run_q;
  logic [rds_pkg::PIN_N-1:0] analog;
  always_comb begin
    for (int i = 0; i < rds_pkg::PIN_N; i++) begin
      analog[i] = (i > 1) && (pin_config[2*i +: 2] == rds_pkg::PIN_CFG_ANALOG);
    end
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_run_q <= 16'h0;
      self_run_q <= 16'h0;
    end else begin
      pin_run_q <= (|pin_pulldown_en) ? pin_run_q + 16'h1 : 16'h0;
      self_run_q <= self_check_run ? self_run_q + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_start_busy: assert property ((soc_pulse || cycle_pulse) && !busy |=> busy)
    else $error("start not followed by busy");
  a_pin_len: assert property ($fell(|pin_pulldown_en) |->
    pin_run_q == 16'(rds_pkg::PIN_OPEN_SETTLE_CYC + FAST_CONV_CYC)) else $error("pin step length wrong");
  a_pin_skip: assert property ((pin_pulldown_en & ~analog) == '0)
    else $error("skipped pin tested");
  a_cell_mask: assert property ((cell_open_test_en & ~{cell_channel_enable, cell_channel_enable[0]}) == '0)
    else $error("disabled terminal tested");
  a_bal_mask: assert property ((balance_test_en & ~cell_channel_enable) == '0)
    else $error("disabled segment tested");
  a_step_excl: assert property ($onehot0({|pin_pulldown_en, |cell_open_test_en,
    |balance_test_en, self_check_run})) else $error("steps overlap");
  a_self_len: assert property ($fell(self_check_run) |-> self_run_q == 16'(3 * FAST_CONV_CYC))
    else $error("self-check length wrong");
  a_self_done: assert property ($fell(self_check_run) |-> self_check_finished && diag_done)
    else $error("done flag not set");
  a_done_clear: assert property (done_read && !self_check_run |=> !self_check_finished)
    else $error("done flag not cleared");
  a_fault_ovr: assert property (faults != '0 |-> config_override)
    else $error("fault without override");
  a_fault_hold: assert property (!fault_clear |=> (faults & $past(faults)) == $past(faults))
    else $error("fault lost");
  a_end_pulse: assert property (diag_done |-> !busy ##1 !diag_done)
    else $error("end pulse wrong");
endmodule : rds_seq_chk

bind rds_seq rds_seq_chk #(.FAST_CONV_CYC(FAST_CONV_CYC)) rds_seq_chk_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .soc_pulse(soc_pulse), .cycle_pulse(cycle_pulse),
  .pin_config(pin_config), .cell_channel_enable(cell_channel_enable), .fault_clear(fault_clear),
  .done_read(done_read), .busy(busy), .diag_done(diag_done), .pin_pulldown_en(pin_pulldown_en),
  .cell_open_test_en(cell_open_test_en), .balance_test_en(balance_test_en), .self_check_run(self_check_run),
  .faults(faults), .config_override(config_override), .self_check_finished(self_check_finished));
`default_nettype wire

// ==== rds_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module rds_host_model (
  input wire logic core_clk, // Clock.
  output logic soc_pulse, // Start pulse.
  output rds_pkg::rds_req_t soc_req, // Step requests.
  output logic cycle_pulse, // Cyclic start.
  output logic fault_clear, // Fault clear.
  output logic done_read // Flag read.
);
  initial begin
    soc_pulse = 1'b0;
    soc_req = '0;
    cycle_pulse = 1'b0;
    fault_clear = 1'b0;
    done_read = 1'b0;
  end
  // Requests only travel with the start; afterwards the lines show junk.
  task automatic start(input rds_pkg::rds_req_t req, input logic cyc);
    @(negedge core_clk);
    soc_req = req;
    soc_pulse = !cyc;
    cycle_pulse = cyc;
    @(negedge core_clk);
    soc_pulse = 1'b0;
    cycle_pulse = 1'b0;
    soc_req = ~req;
  endtask : start
  task automatic read_done();
    @(negedge core_clk);
    done_read = 1'b1;
    @(negedge core_clk);
    done_read = 1'b0;
  endtask : read_done
  task automatic clear_faults();
    @(negedge core_clk);
    fault_clear = 1'b1;
    @(negedge core_clk);
    fault_clear = 1'b0;
  endtask : clear_faults
endmodule : rds_host_model
`default_nettype wire

// ==== routine_diagnostic_steps_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module routine_diagnostic_steps_tb_top;
  localparam int FC = 4;
  localparam int D_PIN = rds_pkg::PIN_OPEN_SETTLE_CYC + FC;
  localparam int D_BAL = 2 * rds_pkg::BAL_OPENLOAD_CYC;
  localparam int D_SELF = 3 * FC;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic prior_done = 1'b0;
  logic converter_cross_verify = 1'b1;
  logic [2:0] filter_soc = 3'h1;
  logic [2:0] filter_cycle = 3'h0;
  logic [17:0] pin_config = 18'h3fcc0;
  logic [13:0] cell_channel_enable = 14'h0005;
  rds_pkg::rds_ncyc_t ncycle = '0;
  rds_pkg::rds_sense_t sense = '0;
  rds_pkg::rds_req_t soc_req;
  rds_pkg::rds_fault_t faults;
  logic soc_pulse, cycle_pulse, fault_clear, done_read, busy, diag_done, cell_cross_mode;
  logic self_check_run, config_override, self_check_finished;
  logic [8:0] pin_pulldown_en, seen_pin;
  logic [14:0] cell_open_test_en, seen_cell;
  logic [13:0] balance_test_en, seen_bal;
  logic seen_cross;
  int n[4], first[4], last[4], ndone, err_count, checked;

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  rds_host_model rds_host_model_inst (.core_clk(core_clk), .soc_pulse(soc_pulse), .soc_req(soc_req),
    .cycle_pulse(cycle_pulse), .fault_clear(fault_clear), .done_read(done_read));
  rds_seq #(.FAST_CONV_CYC(FC)) rds_seq_inst (.core_clk(core_clk), .sys_rst(sys_rst), .soc_pulse(soc_pulse),
    .soc_req(soc_req), .cycle_pulse(cycle_pulse), .prior_done(prior_done), .ncycle(ncycle), .pin_config(pin_config),
    .cell_channel_enable(cell_channel_enable), .converter_cross_verify(converter_cross_verify),
    .filter_soc(filter_soc), .filter_cycle(filter_cycle), .sense(sense), .fault_clear(fault_clear),
    .done_read(done_read), .busy(busy), .diag_done(diag_done), .pin_pulldown_en(pin_pulldown_en),
    .cell_open_test_en(cell_open_test_en), .cell_cross_mode(cell_cross_mode), .balance_test_en(balance_test_en),
    .self_check_run(self_check_run), .faults(faults), .config_override(config_override),
    .self_check_finished(self_check_finished));

  // ----
  // Checks and transfers
  // ----
  task automatic check_vec(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: value %0h, expected %0h", $time, got, exp);
    end
  endtask : check_vec
  task automatic check_int(input int got, input int exp);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("ERROR %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask : check_int
  function automatic int d_cell(input int f);
    return 2 * (rds_pkg::CELL_OPEN_SETTLE_CYC + (FC << f));
  endfunction : d_cell
  // Starts a routine, signals the earlier steps done, then logs each step.
  task automatic run(input rds_pkg::rds_req_t req, input logic cyc);
    logic [3:0] act;
    int t;
    rds_host_model_inst.start(req, cyc);
    @(negedge core_clk);
    prior_done = 1'b1;
    @(negedge core_clk);
    prior_done = 1'b0;
    n = '{0, 0, 0, 0};
    first = '{-1, -1, -1, -1};
    ndone = 0;
    seen_pin = '0;
    seen_cell = '0;
    seen_bal = '0;
    seen_cross = 1'b0;
    for (t = 0; t < 20000; t++) begin
      act = {self_check_run === 1'b1, |balance_test_en, |cell_open_test_en, |pin_pulldown_en};
      for (int j = 0; j < 4; j++) begin
        if (act[j]) begin
          n[j]++;
          last[j] = t;
          if (first[j] < 0) first[j] = t;
        end
      end
      seen_pin |= pin_pulldown_en;
      seen_cell |= cell_open_test_en;
      seen_bal |= balance_test_en;
      if (act[1]) seen_cross |= cell_cross_mode;
      if (diag_done === 1'b1) ndone++;
      if (busy !== 1'b1) break;
      @(negedge core_clk);
    end
    if (t == 20000) check_int(t, 0);
  endtask : run
  task automatic wrap_up();
    $display("Comparisons %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
  initial begin
    rds_pkg::rds_fault_t exp_f;
    repeat (16) @(negedge core_clk);
    sys_rst = 1'b0;
    check_vec(64'({faults, busy, config_override, self_check_finished}), 64'h0);
    sense.bist = '1;
    run(4'h8, 1'b0);
    check_int(n[0] + n[1] + n[2], 0);
    check_int(n[3], D_SELF);
    exp_f = '0;
    exp_f.bist = '1;
    check_vec(64'(faults), 64'(exp_f));
    check_vec(64'({config_override, self_check_finished, ndone[0]}), 64'h7);
    rds_host_model_inst.read_done();
    check_vec(64'(self_check_finished), 64'h0);
    rds_host_model_inst.clear_faults();
    check_vec(64'({faults, config_override}), 64'h0);
    sense = '1;
    run(4'hf, 1'b0);
    check_int(n[0], D_PIN);
    check_int(n[1], d_cell(1));
    check_int(n[2], D_BAL);
    check_int(n[3], D_SELF);
    check_int(int'(last[0] < first[1] && last[1] < first[2] && last[2] < first[3]), 1);
    check_vec(64'({seen_pin, seen_cell, seen_bal, seen_cross}),
      64'({9'h014, 15'h000b, 14'h0005, 1'b1}));
    exp_f = '{pin_open: 9'h014, cell_open: 15'h000b, balance_open: 14'h0005, bist: '1};
    check_vec(64'({faults, config_override}), 64'({exp_f, 1'b1}));
    rds_host_model_inst.clear_faults();
    sense = '0;
    run(4'h0, 1'b0);
    check_vec(64'({busy, ndone[0]}), 64'h0);
    ncycle.self_check = 3'h2;
    for (int k = 0; k < 5; k++) begin
      run(4'h0, 1'b1);
      check_int(n[3], (k % 4 == 0) ? D_SELF : 0);
      check_int(n[0] + n[1] + n[2], 0);
    end
    ncycle = '{self_check: 3'h0, balance_path: 3'h0, cell_open: 3'h1, pin_open: 3'h0};
    filter_cycle = 3'h2;
    filter_soc = 3'h0;
    converter_cross_verify = 1'b0;
    run(4'h0, 1'b1);
    check_int(n[1], d_cell(2));
    check_vec(64'(seen_cross), 64'h0);
    wrap_up();
  end
endmodule : routine_diagnostic_steps_tb_top
`default_nettype wire
